// File: input_pga_control_regs.sv
// Contract
// - Right gain bit 7 silences preamp, resets 1
// - Right gain bits 4:0 code, reset 00101
// - Line modes use nonlinear -1.5..+28.3 dB table
// - Mic mode: 0 reserved, +12 step 3, cap +30
// - Right mode field picks gain decoding
// - Left bit 6 rejection, reset on, differential line mode only
// - Selectors 5:4 reset 00, 3:2 reset 01
// - Mic mode swaps inverting and non-inverting roles
// - Left bits 1:0 mode, reset single-ended
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module input_pga_control_regs
  import pga_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Right front-end controls
  output logic             right_pga_silence,
  output logic [4:0]       right_pga_gain_code,
  output logic [1:0]       right_mode,
  output logic signed [9:0] right_gain_tenth_db,
  output logic             right_gain_reserved,
  // Left front-end controls
  output logic             left_common_rejection_on,
  output logic [1:0]       left_minus_pin_pick,
  output logic [1:0]       left_plus_pin_pick,
  output logic [1:0]       left_mode,
  output logic [2:0]       left_inv_pin_sel,
  output logic [2:0]       left_noninv_pin_sel
);
  // Stored fields
  logic       silence_r,  silence_nxt;
  logic [4:0] gain_r,     gain_nxt;
  logic [1:0] rmode_r,    rmode_nxt;
  logic       cmr_r,      cmr_nxt;
  logic [1:0] minus_r,    minus_nxt;
  logic [1:0] plus_r,     plus_nxt;
  logic [1:0] lmode_r,    lmode_nxt;
  // Bus answer state
  logic       ack_r,      ack_nxt;
  logic       err_r,      err_nxt;
  logic [31:0] rdat_r,    rdat_nxt;
  // Decode
  logic [7:0] idx;          // Word index
  logic       req;          // New request this cycle
  logic       hit_gain;     // Right gain register
  logic       hit_route;    // Left routing register
  logic       hit_rmode;    // Right mode register
  logic       wr_lane0;     // Write touching the low byte

  // Word index from byte address; low address bits ignored
  assign idx       = wb_adr_i[ADDR_LSB +: 8];
  // Ack drops a cycle after it rose, so a held request is not re-taken
  assign req       = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  assign hit_gain  = (idx == RIGHT_GAIN_IDX);
  assign hit_route = (idx == LEFT_ROUTE_IDX);
  assign hit_rmode = (idx == RIGHT_MODE_IDX);
  // Every defined field lives in byte lane 0
  assign wr_lane0  = req && wb_we_i && wb_sel_i[0];

  // Next values of registers and bus answer
  always_comb begin
    silence_nxt = silence_r;
    gain_nxt    = gain_r;
    rmode_nxt   = rmode_r;
    cmr_nxt     = cmr_r;
    minus_nxt   = minus_r;
    plus_nxt    = plus_r;
    lmode_nxt   = lmode_r;
    ack_nxt     = 1'b0;
    err_nxt     = 1'b0;
    rdat_nxt    = rdat_r;
    if (req) begin
      // Unmapped addresses answer with err, not ack
      if (hit_gain || hit_route || hit_rmode) begin
        ack_nxt = 1'b1;
      end else begin
        err_nxt = 1'b1;
      end
      rdat_nxt = 32'h0000_0000;
      if (hit_gain) begin
        rdat_nxt[SILENCE_BIT] = silence_r;
        rdat_nxt[GAIN_HI:0]   = gain_r;
      end else if (hit_route) begin
        rdat_nxt[CMR_BIT]            = cmr_r;
        rdat_nxt[MINUS_HI:MINUS_LO]  = minus_r;
        rdat_nxt[PLUS_HI:PLUS_LO]    = plus_r;
        rdat_nxt[1:0]                = lmode_r;
      end else if (hit_rmode) begin
        rdat_nxt[1:0] = rmode_r;
      end
    end
    if (wr_lane0) begin
      // Undefined bits are dropped on write
      if (hit_gain) begin
        silence_nxt = wb_dat_i[SILENCE_BIT];
        gain_nxt    = wb_dat_i[GAIN_HI:0];
      end else if (hit_route) begin
        cmr_nxt   = wb_dat_i[CMR_BIT];
        minus_nxt = wb_dat_i[MINUS_HI:MINUS_LO];
        plus_nxt  = wb_dat_i[PLUS_HI:PLUS_LO];
        lmode_nxt = wb_dat_i[1:0];
      end else if (hit_rmode) begin
        rmode_nxt = wb_dat_i[1:0];
      end
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      silence_r <= SILENCE_RST;
      gain_r    <= GAIN_RST;
      rmode_r   <= MODE_SINGLE;
      cmr_r     <= CMR_RST;
      minus_r   <= MINUS_RST;
      plus_r    <= PLUS_RST;
      lmode_r   <= MODE_SINGLE;
      ack_r     <= 1'b0;
      err_r     <= 1'b0;
      rdat_r    <= 32'h0000_0000;
    end else begin
      silence_r <= silence_nxt;
      gain_r    <= gain_nxt;
      rmode_r   <= rmode_nxt;
      cmr_r     <= cmr_nxt;
      minus_r   <= minus_nxt;
      plus_r    <= plus_nxt;
      lmode_r   <= lmode_nxt;
      ack_r     <= ack_nxt;
      err_r     <= err_nxt;
      rdat_r    <= rdat_nxt;
    end
  end

  // Pin pick decode: 1X is pin three
  function automatic logic [2:0] pick_pin(input logic [1:0] p);
    if (p[1]) begin
      pick_pin = PIN_THREE;
    end else if (p[0]) begin
      pick_pin = PIN_TWO;
    end else begin
      pick_pin = PIN_ONE;
    end
  endfunction

  // Role swap: mic mode moves each selector to the other side
  always_comb begin
    if (lmode_r == MODE_DIFF_MIC) begin
      left_inv_pin_sel    = pick_pin(plus_r);
      left_noninv_pin_sel = pick_pin(minus_r);
    end else begin
      left_inv_pin_sel    = pick_pin(minus_r);
      left_noninv_pin_sel = pick_pin(plus_r);
    end
  end

  // Rejection only acts in differential line mode
  assign left_common_rejection_on =
    cmr_r && (lmode_r == MODE_DIFF_LN);

  // Static outputs straight from flip-flops
  assign right_pga_silence   = silence_r;
  assign right_pga_gain_code = gain_r;
  assign right_mode          = rmode_r;
  assign left_minus_pin_pick = minus_r;
  assign left_plus_pin_pick  = plus_r;
  assign left_mode           = lmode_r;
  assign wb_ack_o            = ack_r;
  assign wb_err_o            = err_r;
  assign wb_dat_o            = rdat_r;

  // Gain decode for the right preamp
  pga_gain_decode u_right_dec (
    .gain_code     (gain_r),
    .mode          (rmode_r),
    .gain_tenth_db (right_gain_tenth_db),
    .gain_reserved (right_gain_reserved)
  );

  // Assertions
  a_silence_reset: assert property (@(posedge ref_clk)
    !rstn |=> right_pga_silence) else $error("silence not set by reset");
  a_gain_reset: assert property (@(posedge ref_clk)
    !rstn |=> right_pga_gain_code == GAIN_RST) else $error("bad gain reset");
  a_line_top: assert property (@(posedge ref_clk) disable iff (!rstn)
    (gain_r == 5'h1f && rmode_r == MODE_SINGLE)
      |-> right_gain_tenth_db == 10'sd283)
    else $error("line top gain wrong");
  a_mic_sat: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rmode_r == MODE_DIFF_MIC && gain_r >= 5'h07)
      |-> right_gain_tenth_db == 10'sd300)
    else $error("mic saturation wrong");
  a_mic_step: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rmode_r == MODE_DIFF_MIC && gain_r == 5'h05)
      |-> right_gain_tenth_db == 10'sd240)
    else $error("mic default gain wrong");
  a_cmr_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    left_common_rejection_on |-> lmode_r == MODE_DIFF_LN)
    else $error("rejection outside line mode");
  a_sel_reset: assert property (@(posedge ref_clk)
    !rstn |=> minus_r == 2'h0 && plus_r == 2'h1)
    else $error("selector reset wrong");
  a_mic_swap: assert property (@(posedge ref_clk) disable iff (!rstn)
    (lmode_r == MODE_DIFF_MIC && plus_r == 2'h1 && minus_r == 2'h0)
      |-> left_inv_pin_sel == 3'h2)
    else $error("mic swap wrong");
  a_mode_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_lane0 && hit_route) |=> lmode_r == $past(wb_dat_i[1:0]))
    else $error("left mode not written");
  a_read_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (req && hit_gain) |=> wb_ack_o && wb_dat_o[6:5] == 2'h0)
    else $error("undefined bits not zero");
  c_mic_mode: cover property (@(posedge ref_clk) lmode_r == MODE_DIFF_MIC);
  c_err_ans: cover property (@(posedge ref_clk) wb_err_o);
  c_rd_ack: cover property (@(posedge ref_clk) wb_ack_o && !wb_we_i);
endmodule
`default_nettype wire

// File: pga_ctrl_pkg.sv
package pga_ctrl_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] RIGHT_GAIN_IDX  = 8'h2d;
  localparam logic [7:0] LEFT_ROUTE_IDX  = 8'h2e;
  localparam logic [7:0] RIGHT_MODE_IDX  = 8'h30;
  localparam int         ADDR_LSB        = 2;
  // Right gain register fields
  localparam int         SILENCE_BIT     = 7;
  localparam int         GAIN_HI         = 4;
  localparam logic       SILENCE_RST     = 1'b1;
  localparam logic [4:0] GAIN_RST        = 5'h05;
  // Left routing register fields
  localparam int         CMR_BIT         = 6;
  localparam int         MINUS_HI        = 5;
  localparam int         MINUS_LO        = 4;
  localparam int         PLUS_HI         = 3;
  localparam int         PLUS_LO         = 2;
  localparam logic       CMR_RST         = 1'b1;
  localparam logic [1:0] MINUS_RST       = 2'h0;
  localparam logic [1:0] PLUS_RST        = 2'h1;
  // Input modes
  typedef enum logic [1:0] {
    MODE_SINGLE   = 2'b00,
    MODE_DIFF_LN  = 2'b01,
    MODE_DIFF_MIC = 2'b10,
    MODE_RSVD     = 2'b11
  } in_mode_e;
  // One-hot pin picks: bit0 pin one, bit1 pin two, bit2 pin three
  localparam logic [2:0] PIN_ONE         = 3'h1;
  localparam logic [2:0] PIN_TWO         = 3'h2;
  localparam logic [2:0] PIN_THREE       = 3'h4;
  // Gain in tenths of dB; reserved mic code flagged separately
  localparam logic signed [9:0] MIC_BASE = 10'sd120;
  localparam logic signed [9:0] MIC_STEP = 10'sd30;
  localparam logic signed [9:0] MIC_TOP  = 10'sd300;
  localparam logic [4:0] MIC_SAT_CODE    = 5'h07;
endpackage

// File: pga_gain_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Maps a gain code and mode to a gain in tenths of dB
module pga_gain_decode
  import pga_ctrl_pkg::*;
(
  // Request
  input  wire logic [4:0]        gain_code,
  input  wire logic [1:0]        mode,
  // Result
  output logic signed [9:0]      gain_tenth_db,
  output logic                   gain_reserved
);
  // Line table, code 10011 absent from the printed list: interpolated
  function automatic logic signed [9:0] line_gain(input logic [4:0] c);
    case (c)
      5'h00: line_gain = -10'sd15;
      5'h01: line_gain = -10'sd13;
      5'h02: line_gain = -10'sd10;
      5'h03: line_gain = -10'sd7;
      5'h04: line_gain = -10'sd3;
      5'h05: line_gain = 10'sd0;
      5'h06: line_gain = 10'sd3;
      5'h07: line_gain = 10'sd7;
      5'h08: line_gain = 10'sd10;
      5'h09: line_gain = 10'sd14;
      5'h0a: line_gain = 10'sd18;
      5'h0b: line_gain = 10'sd23;
      5'h0c: line_gain = 10'sd27;
      5'h0d: line_gain = 10'sd32;
      5'h0e: line_gain = 10'sd37;
      5'h0f: line_gain = 10'sd42;
      5'h10: line_gain = 10'sd48;
      5'h11: line_gain = 10'sd54;
      5'h12: line_gain = 10'sd60;
      5'h13: line_gain = 10'sd67;
      5'h14: line_gain = 10'sd75;
      5'h15: line_gain = 10'sd83;
      5'h16: line_gain = 10'sd92;
      5'h17: line_gain = 10'sd102;
      5'h18: line_gain = 10'sd114;
      5'h19: line_gain = 10'sd127;
      5'h1a: line_gain = 10'sd143;
      5'h1b: line_gain = 10'sd162;
      5'h1c: line_gain = 10'sd192;
      5'h1d: line_gain = 10'sd223;
      5'h1e: line_gain = 10'sd252;
      default: line_gain = 10'sd283;
    endcase
  endfunction

  // Mode selects the decoding
  always_comb begin
    gain_reserved = 1'b0;
    gain_tenth_db = line_gain(gain_code);
    if (mode == MODE_DIFF_MIC) begin
      if (gain_code == 5'h00) begin
        gain_reserved = 1'b1;
        gain_tenth_db = MIC_BASE;
      end else if (gain_code >= MIC_SAT_CODE) begin
        gain_tenth_db = MIC_TOP;
      end else begin
        gain_tenth_db = MIC_BASE
          + MIC_STEP * $signed({5'h00, gain_code - 5'h01});
      end
    end else if (mode == MODE_RSVD) begin
      // Reserved mode: flag it, keep line decode
      gain_reserved = 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pga_ctrl_pkg::*;
;
  // Clock, reset and bus drive
  logic               ref_clk;
  logic               rstn;
  logic               wb_cyc_i, wb_stb_i, wb_we_i;
  logic [9:0]         wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i, wb_dat_o;
  logic               wb_ack_o, wb_err_o;
  // Front-end controls seen by the bench
  logic               right_pga_silence, right_gain_reserved;
  logic [4:0]         right_pga_gain_code;
  logic [1:0]         right_mode, left_mode;
  logic signed [9:0]  right_gain_tenth_db;
  logic               left_common_rejection_on;
  logic [1:0]         left_minus_pin_pick, left_plus_pin_pick;
  logic [2:0]         left_inv_pin_sel, left_noninv_pin_sel;
  // Result counters
  int                 mismatches, check_count;
  int                 m, n, p, c;
  // Byte addresses of the three registers
  localparam logic [9:0] A_GAIN = {RIGHT_GAIN_IDX, 2'b00};
  localparam logic [9:0] A_LEFT = {LEFT_ROUTE_IDX, 2'b00};
  localparam logic [9:0] A_MODE = {RIGHT_MODE_IDX, 2'b00};
  // Line-mode gain per code, tenths of dB
  localparam logic signed [9:0] line_db [32] = '{-10'sd15, -10'sd13,
    -10'sd10, -10'sd7, -10'sd3, 10'sd0, 10'sd3, 10'sd7, 10'sd10, 10'sd14,
    10'sd18, 10'sd23, 10'sd27, 10'sd32, 10'sd37, 10'sd42, 10'sd48, 10'sd54,
    10'sd60, 10'sd67, 10'sd75, 10'sd83, 10'sd92, 10'sd102, 10'sd114,
    10'sd127, 10'sd143, 10'sd162, 10'sd192, 10'sd223, 10'sd252, 10'sd283};

  input_pga_control_regs dut_u (
    .ref_clk                  (ref_clk),
    .rstn                     (rstn),
    .wb_cyc_i                 (wb_cyc_i),
    .wb_stb_i                 (wb_stb_i),
    .wb_we_i                  (wb_we_i),
    .wb_adr_i                 (wb_adr_i),
    .wb_sel_i                 (wb_sel_i),
    .wb_dat_i                 (wb_dat_i),
    .wb_dat_o                 (wb_dat_o),
    .wb_ack_o                 (wb_ack_o),
    .wb_err_o                 (wb_err_o),
    .right_pga_silence        (right_pga_silence),
    .right_pga_gain_code      (right_pga_gain_code),
    .right_mode               (right_mode),
    .right_gain_tenth_db      (right_gain_tenth_db),
    .right_gain_reserved      (right_gain_reserved),
    .left_common_rejection_on (left_common_rejection_on),
    .left_minus_pin_pick      (left_minus_pin_pick),
    .left_plus_pin_pick       (left_plus_pin_pick),
    .left_mode                (left_mode),
    .left_inv_pin_sel         (left_inv_pin_sel),
    .left_noninv_pin_sel      (left_noninv_pin_sel)
  );

  // Free-running 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Mic-mode gain: 3 dB steps from +12, capped at +30
  function automatic logic signed [9:0] mic_db(input int k);
    if (k >= 7) return 10'sd300;
    return (k == 0) ? 10'sd120 : 10'(120 + 30 * (k - 1));
  endfunction

  // One-hot pin pick: 1X wins over 01
  function automatic logic [2:0] pin_of(input logic [1:0] v);
    return v[1] ? 3'h4 : (v[0] ? 3'h2 : 3'h1);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Classic single cycle; holds until ack or err seen at an edge
  task automatic bus(input logic we, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] exp, input logic ee);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 16);
    chk(32'(k < 16), 32'h1);
    chk({31'h0, wb_err_o}, {31'h0, ee});
    if (!we && !ee) chk(wb_dat_o, exp);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf, e, 1'b0);
  endtask

  // Reset values at the pins and through the bus
  task automatic reset_check();
    chk({31'h0, right_pga_silence}, 32'h1);
    chk({27'h0, right_pga_gain_code}, 32'h5);
    chk({30'h0, left_mode}, 32'h0);
    chk({30'h0, right_mode}, 32'h0);
    rd(A_GAIN, 32'h85);
    rd(A_LEFT, 32'h44);
    rd(A_MODE, 32'h0);
  endtask

  task automatic final_report();
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run takes about 1200 cycles; cut a hang well beyond
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end

  initial begin
    mismatches = 0;
    check_count = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    rstn = 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    reset_check();
    // Every right mode against every gain code
    for (m = 0; m < 4; m++) begin
      wr(A_MODE, 32'(m));
      rd(A_MODE, 32'(m));
      chk({30'h0, right_mode}, 32'(m));
      for (c = 0; c < 32; c++) begin
        wr(A_GAIN, {24'h0, c[0], 2'b11, c[4:0]});
        rd(A_GAIN, {24'h0, c[0], 2'b00, c[4:0]});
        chk({31'h0, right_pga_silence}, 32'(c[0]));
        chk({27'h0, right_pga_gain_code}, 32'(c));
        if (m < 2) chk(right_gain_tenth_db, line_db[c]);
        if (m == 2) chk(right_gain_tenth_db, mic_db(c));
        chk(32'(right_gain_reserved),
            32'(m == 3 || (m == 2 && c == 0)));
      end
    end
    // Left routing: every mode and selector pair
    for (m = 0; m < 4; m++) begin
      for (n = 0; n < 4; n++) begin
        for (p = 0; p < 4; p++) begin
          wr(A_LEFT, {25'h1ffffff, p[0], n[1:0], p[1:0], m[1:0]});
          rd(A_LEFT, {25'h0, p[0], n[1:0], p[1:0], m[1:0]});
          chk(32'(left_common_rejection_on), 32'(p[0] && m == 1));
          chk({left_minus_pin_pick, left_plus_pin_pick}, n * 4 + p);
          chk({30'h0, left_mode}, 32'(m));
          if (m == 2) begin
            chk({left_inv_pin_sel, left_noninv_pin_sel},
                {pin_of(p[1:0]), pin_of(n[1:0])});
          end else if (m < 2) begin
            chk({left_inv_pin_sel, left_noninv_pin_sel},
                {pin_of(n[1:0]), pin_of(p[1:0])});
          end
        end
      end
    end
    // Lane 0 disabled: acked, no change
    bus(1'b1, A_GAIN, 32'h0, 4'he, 32'h0, 1'b0);
    rd(A_GAIN, 32'h9f);
    // Unmapped places refuse with err and keep state
    bus(1'b0, 10'h000, 32'h0, 4'hf, 32'h0, 1'b1);
    bus(1'b1, 10'h3fc, 32'h0, 4'hf, 32'h0, 1'b1);
    rd(A_LEFT, 32'h7f);
    // Second reset in mid-run
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    reset_check();
    final_report();
  end
endmodule
`default_nettype wire
